//--- sebs_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module sebs_motor_model (
  input  wire logic        clock,
  input  wire logic        motorPower,
  input  wire logic        brakeRelease,
  input  wire logic        kick,
  input  wire logic [15:0] kickSpeed,
  output logic      [15:0] motorSpeed
);
  // ----------------------------------------
  // load motion
  // ----------------------------------------
  // kick forces a speed; unpowered it coasts, faster with the brake held
  always_ff @(posedge clock) begin
    if (kick) begin
      motorSpeed <= kickSpeed;
    end else if (!motorPower && motorSpeed != 16'h0000) begin
      motorSpeed <= (brakeRelease || motorSpeed < 16'h0004) ? motorSpeed - 16'h0001 : motorSpeed - 16'h0004;
    end
  end
endmodule
`default_nettype wire

//--- sebs_pkg.sv
`default_nettype none
package sebs_pkg;
  // control clock
  localparam int unsigned CLOCK_HZ       = 25000000;
  // dynamic brake release lead before power-up, about 2 ms
  localparam int unsigned DB_LEAD_US     = 2000;
  localparam int unsigned DB_LEAD_CYC    = DB_LEAD_US * (CLOCK_HZ / 1000000);
  // power-up to brake release request, about 4 ms
  localparam int unsigned RELEASE_US     = 4000;
  localparam int unsigned RELEASE_CYC    = RELEASE_US * (CLOCK_HZ / 1000000);
  // one unit of the programmed brake timings, 1 ms
  localparam int unsigned TICK_US        = 1000;
  localparam int unsigned TICK_CYC       = TICK_US * (CLOCK_HZ / 1000000);
  // servo-on speed threshold, 30 mm/s
  localparam logic [15:0] ON_SPEED_MMS   = 16'h001e;
  // command warning code
  localparam logic [7:0]  WARN_CMD       = 8'hb1;
  localparam logic [7:0]  WARN_NONE      = 8'h00;
  // option code for dynamic brake: 0 = free run, else dynamic brake engaged
  localparam logic [2:0]  OPT_FREE_RUN   = 3'h0;
  // fault codes
  localparam logic [1:0]  FAULT_NONE     = 2'h0;
  localparam logic [1:0]  FAULT_EXT      = 2'h1;
  localparam logic [1:0]  FAULT_POWER    = 2'h2;

  // sequencer states, gray along off -> wait -> energise -> on
  typedef enum logic [2:0] {
    SEBS_OFF     = 3'b000,
    SEBS_DBREL   = 3'b001,
    SEBS_POWERUP = 3'b011,
    SEBS_ON      = 3'b010,
    SEBS_STOPOFF = 3'b110,
    SEBS_RUNOFF  = 3'b111,
    SEBS_COAST   = 3'b101,
    SEBS_FAULT   = 3'b100
  } sebs_state_t;
endpackage
`default_nettype wire

//--- sebs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Servo on is only entered while measured speed is at or below 30 mm/s.
// - A servo on command in the off state while the motor moves above 30 mm/s raises warning B1 and waits until the speed is at or below 30 mm/s.
// - The brake release output is the OR of the internal and network release requests.
// - After servo off or a fault in motion the release drops at the earlier of the delay or the speed threshold.
// - A servo on reasserted during deceleration is not honoured until the motor has stopped.
// - On servo off the dynamic brake follows the disable option code.
// - On a fault while on the dynamic brake follows the fault reaction option code until the motor stops, then engages.
// - After fault reset the drive goes off and starts again while servo on is high, with no fresh command edge needed.
// - Loss of main power while on is a power fault and takes the fault shutdown path.
// - Servo off at rest waits the stopped brake time before dropping release and power.
// - The network brake bit counts only when its mask is set; 0 releases, 1 engages.
// - A network brake engage while servo on raises warning B1.
module sebs_sequencer #(
  parameter int unsigned TW          = 24,
  parameter int unsigned DB_LEAD_CYC = sebs_pkg::DB_LEAD_CYC,
  parameter int unsigned RELEASE_CYC = sebs_pkg::RELEASE_CYC,
  parameter int unsigned TICK_CYC    = sebs_pkg::TICK_CYC
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        servoOnCmd,
  input  wire logic        faultIn,
  input  wire logic        mainPowerOk,
  input  wire logic        faultReset,
  input  wire logic [15:0] motorSpeed,
  input  wire logic [15:0] stoppedBrakeTime,
  input  wire logic [15:0] movingBrakeDelayPeriod,
  input  wire logic [15:0] movingBrakeSpeed,
  input  wire logic [2:0]  disableOption,
  input  wire logic [2:0]  faultOption,
  input  wire logic        netBrakeSet,
  input  wire logic        netBrakeMask,
  output logic             holdingBrakeReleaseOut,
  output logic             dynamicShortBrake,
  output logic             motorPower,
  output logic             servoIsOn,
  output logic             faultActive,
  output logic [1:0]       faultCode,
  output logic [7:0]       warningCode,
  output logic             warningPulse
);
  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rstSync1;
  logic rstSync2;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end

  // elaboration check: every step load must fit the step timer
  if (TW < 24 || (DB_LEAD_CYC >> TW) != 0 || (RELEASE_CYC >> TW) != 0 ||
      (TICK_CYC >> TW) != 0) begin : g_badTiming
    $error("timer width too small for the step times");
  end

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  // step times in clock cycles, shortened only by a bench
  localparam logic [TW-1:0] DB_LEAD_LD  = TW'(DB_LEAD_CYC);
  localparam logic [TW-1:0] RELEASE_LD  = TW'(RELEASE_CYC);
  localparam logic [TW-1:0] TICK_LD     = TW'(TICK_CYC);

  sebs_pkg::sebs_state_t state;
  sebs_pkg::sebs_state_t next_state;
  logic        tmrLoad;
  logic [TW-1:0] tmrValue;
  logic        tmrDone;
  logic [15:0] msCount;
  logic [15:0] next_msCount;
  logic        seqRelease;
  logic        next_seqRelease;
  logic        dbEngaged;
  logic        next_dbEngaged;
  logic        power;
  logic        next_power;
  logic        fault;
  logic        next_fault;
  logic [1:0]  fcode;
  logic [1:0]  next_fcode;
  logic [7:0]  warn;
  logic [7:0]  next_warn;
  logic        warnP;
  logic        next_warnP;
  logic        onCmdPrev;
  logic        speedLow;
  logic        stopped;
  logic        onRise;
  logic        netEngage;

  sebs_timer #(.WIDTH(TW)) stepTimer (
    .clock (clock),
    .rstn  (rstSync2),
    .load  (tmrLoad),
    .value (tmrValue),
    .done  (tmrDone)
  );

  assign speedLow  = motorSpeed <= sebs_pkg::ON_SPEED_MMS;
  assign stopped   = motorSpeed == 16'h0000;
  assign onRise    = servoOnCmd && !onCmdPrev;
  assign netEngage = netBrakeMask && netBrakeSet;

  // ------------------------------------------------------------
  // sequencer next state
  // ------------------------------------------------------------
  always_comb begin
    next_state      = state;
    next_msCount    = msCount;
    next_seqRelease = seqRelease;
    next_dbEngaged  = dbEngaged;
    next_power      = power;
    next_fault      = fault;
    next_fcode      = fcode;
    next_warn       = warn;
    next_warnP      = 1'b0;
    tmrLoad         = 1'b0;
    tmrValue        = TICK_LD;
    if (netBrakeMask && netBrakeSet && power) begin
      next_warn  = sebs_pkg::WARN_CMD;
      next_warnP = 1'b1;
    end
    case (state)
      sebs_pkg::SEBS_OFF: begin
        next_power      = 1'b0;
        next_seqRelease = 1'b0;
        if (onRise && !speedLow) begin
          next_warn  = sebs_pkg::WARN_CMD;
          next_warnP = 1'b1;
        end else if (servoOnCmd && speedLow && !fault) begin
          next_dbEngaged = 1'b0;
          tmrLoad        = 1'b1;
          tmrValue       = DB_LEAD_LD;
          next_state     = sebs_pkg::SEBS_DBREL;
        end
      end
      sebs_pkg::SEBS_DBREL: begin
        if (tmrDone) begin
          next_power = 1'b1;
          tmrLoad    = 1'b1;
          tmrValue   = RELEASE_LD;
          next_state = sebs_pkg::SEBS_POWERUP;
        end
      end
      sebs_pkg::SEBS_POWERUP: begin
        if (tmrDone) begin
          next_seqRelease = 1'b1;
          next_state      = sebs_pkg::SEBS_ON;
        end
      end
      sebs_pkg::SEBS_ON: begin
        if (!servoOnCmd) begin
          next_msCount = 16'h0000;
          tmrLoad      = 1'b1;
          next_dbEngaged = disableOption != sebs_pkg::OPT_FREE_RUN;
          next_state     = speedLow ? sebs_pkg::SEBS_STOPOFF : sebs_pkg::SEBS_RUNOFF;
        end
      end
      sebs_pkg::SEBS_STOPOFF: begin
        if (tmrDone) begin
          tmrLoad      = 1'b1;
          next_msCount = msCount + 16'h0001;
        end
        if (msCount >= stoppedBrakeTime) begin
          next_seqRelease = 1'b0;
          next_power      = 1'b0;
          next_state      = sebs_pkg::SEBS_OFF;
        end
      end
      sebs_pkg::SEBS_RUNOFF: begin
        next_power = 1'b0;
        if (tmrDone) begin
          tmrLoad      = 1'b1;
          next_msCount = msCount + 16'h0001;
        end
        if (msCount >= movingBrakeDelayPeriod || motorSpeed < movingBrakeSpeed) begin
          next_seqRelease = 1'b0;
          next_state      = sebs_pkg::SEBS_COAST;
        end
      end
      sebs_pkg::SEBS_COAST: begin
        if (stopped) begin
          next_state = fault ? sebs_pkg::SEBS_FAULT : sebs_pkg::SEBS_OFF;
        end
      end
      sebs_pkg::SEBS_FAULT: begin
        next_power      = 1'b0;
        next_seqRelease = 1'b0;
        if (faultReset && !faultIn && mainPowerOk) begin
          next_fault = 1'b0;
          next_fcode = sebs_pkg::FAULT_NONE;
          next_state = sebs_pkg::SEBS_OFF;
        end
      end
      default: begin
        next_state = sebs_pkg::SEBS_OFF;
      end
    endcase
    // power loss or an external fault while energised is a fault
    if (power && !fault && (faultIn || !mainPowerOk)) begin
      next_fault     = 1'b1;
      next_fcode     = faultIn ? sebs_pkg::FAULT_EXT : sebs_pkg::FAULT_POWER;
      next_power     = 1'b0;
      next_msCount   = 16'h0000;
      tmrLoad        = 1'b1;
      tmrValue       = TICK_LD;
      next_dbEngaged = faultOption != sebs_pkg::OPT_FREE_RUN;
      next_state     = sebs_pkg::SEBS_RUNOFF;
    end
    if (state == sebs_pkg::SEBS_COAST && stopped && fault) begin
      next_dbEngaged = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // sequencer registers
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rstSync2) begin
    if (!rstSync2) begin
      state      <= sebs_pkg::SEBS_OFF;
      msCount    <= 16'h0000;
      seqRelease <= 1'b0;
      dbEngaged  <= 1'b1;
      power      <= 1'b0;
      fault      <= 1'b0;
      fcode      <= sebs_pkg::FAULT_NONE;
      warn       <= sebs_pkg::WARN_NONE;
      warnP      <= 1'b0;
      onCmdPrev  <= 1'b0;
    end else begin
      state      <= next_state;
      msCount    <= next_msCount;
      seqRelease <= next_seqRelease;
      dbEngaged  <= next_dbEngaged;
      power      <= next_power;
      fault      <= next_fault;
      fcode      <= next_fcode;
      warn       <= next_warn;
      warnP      <= next_warnP;
      onCmdPrev  <= servoOnCmd;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // release is OR of requests
  assign holdingBrakeReleaseOut = seqRelease || (netBrakeMask && !netEngage);
  assign dynamicShortBrake      = dbEngaged;
  assign motorPower             = power;
  assign servoIsOn              = state == sebs_pkg::SEBS_ON;
  assign faultActive            = fault;
  assign faultCode              = fcode;
  assign warningCode            = warn;
  assign warningPulse           = warnP;
endmodule
`default_nettype wire

//--- sebs_sequencer_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sebs_sequencer_checker (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        servoOnCmd,
  input wire logic        mainPowerOk,
  input wire logic [15:0] motorSpeed,
  input wire logic [2:0]  faultOption,
  input wire logic        netBrakeSet,
  input wire logic        netBrakeMask,
  input wire logic        holdingBrakeReleaseOut,
  input wire logic        dynamicShortBrake,
  input wire logic        motorPower,
  input wire logic        servoIsOn,
  input wire logic        faultActive,
  input wire logic [1:0]  faultCode,
  input wire logic [7:0]  warningCode,
  input wire logic        warningPulse
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // sequencing properties
  // ----------------------------------------
  sequence sAccept; $fell(dynamicShortBrake) && servoOnCmd; endsequence
  sequence sFault; $rose(faultActive); endsequence
  a_net_release_or: assert property (netBrakeMask && !netBrakeSet |-> holdingBrakeReleaseOut)
    else $error("release output low under network release");
  a_speed_gate: assert property (servoOnCmd && !motorPower && motorSpeed > 16'h001e |=> !motorPower)
    else $error("power applied above on speed");
  a_warn_code: assert property (warningPulse |-> warningCode == 8'hb1)
    else $error("warning pulse without command code");
  a_engage_warn: assert property (servoIsOn && netBrakeMask && netBrakeSet |=> warningPulse)
    else $error("no warning for engage while on");
  a_power_fault: assert property (motorPower && !mainPowerOk |-> ##[1:2] faultActive && faultCode == 2'h2)
    else $error("power loss not flagged");
  a_fault_power: assert property (sFault |-> ##[0:1] !motorPower)
    else $error("power kept after fault");
  a_fault_brake: assert property (sFault |-> ##[0:2] dynamicShortBrake == (faultOption != 3'h0))
    else $error("dynamic brake ignores fault option");
  a_step_order: assert property (sAccept |-> !motorPower [*8])
    else $error("power too soon after brake release");
  a_on_ready: assert property ($rose(servoIsOn) |-> motorPower && !dynamicShortBrake && holdingBrakeReleaseOut)
    else $error("on state before its steps");
  a_reset_off: assert property ($fell(faultActive) |-> !servoIsOn && !motorPower)
    else $error("energised after fault reset");
endmodule
bind sebs_sequencer sebs_sequencer_checker chk (.clock, .rstn, .servoOnCmd, .mainPowerOk, .motorSpeed,
  .faultOption, .netBrakeSet, .netBrakeMask, .holdingBrakeReleaseOut, .dynamicShortBrake, .motorPower,
  .servoIsOn, .faultActive, .faultCode, .warningCode, .warningPulse);
`default_nettype wire

//--- sebs_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sebs_sequencer_tb;
  logic        clock, rstn, servoOnCmd, faultIn, mainPowerOk, faultReset, kick, netBrakeSet, netBrakeMask;
  logic        holdingBrakeReleaseOut, dynamicShortBrake, motorPower, servoIsOn, faultActive, warningPulse;
  logic [15:0] motorSpeed, kickSpeed, stoppedBrakeTime, movingBrakeDelayPeriod, movingBrakeSpeed;
  logic [2:0]  disableOption, faultOption;
  logic [1:0]  faultCode;
  logic [7:0]  warningCode;
  logic [7:0]  expQ[$];
  int          n_fail, n_tests, n;
  // shortened step times keep the run brief: dynamic brake lead, release lead, one ms
  localparam int DBC = 200;
  localparam int RLC = 400;
  localparam int TKC = 100;
  sebs_sequencer #(.TW(24), .DB_LEAD_CYC(DBC), .RELEASE_CYC(RLC), .TICK_CYC(TKC)) dut (.clock, .rstn, .servoOnCmd,
    .faultIn, .mainPowerOk, .faultReset, .motorSpeed,
    .stoppedBrakeTime, .movingBrakeDelayPeriod, .movingBrakeSpeed, .disableOption, .faultOption, .netBrakeSet,
    .netBrakeMask, .holdingBrakeReleaseOut, .dynamicShortBrake, .motorPower, .servoIsOn, .faultActive,
    .faultCode, .warningCode, .warningPulse);
  sebs_motor_model partner (.clock, .motorPower, .brakeRelease(holdingBrakeReleaseOut), .kick, .kickSpeed,
    .motorSpeed);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (n_fail == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask
  function automatic logic cond(input int s);
    case (s)
      0: return motorPower === 1'b1;
      1: return servoIsOn === 1'b1;
      2: return holdingBrakeReleaseOut === 1'b0;
      3: return motorSpeed === 16'h0000;
      default: return dynamicShortBrake === 1'b0;
    endcase
  endfunction
  // bounded wait, n holds the edges taken
  task automatic await(input int s, input int lim);
    n = 0;
    while (!cond(s)) begin
      @(posedge clock);
      #1;
      n++;
      if (n >= lim) begin
        n_fail++;
        complete_run();
      end
    end
  endtask
  // power-up steps; lead is the edges from the call to the dynamic brake letting go
  task automatic step_up(input int lead);
    await(0, lead + DBC + 20);
    check(16'(n >= lead + DBC - 2 && n <= lead + DBC + 3), 16'h0001);
    await(1, RLC + 20);
    check(16'(n >= RLC - 2 && n <= RLC + 3), 16'h0001);
  endtask
  // fault reset lands off, then a fresh servo on
  task automatic clear_fault();
    servoOnCmd <= 1'b0;
    mainPowerOk <= 1'b1;
    faultReset <= 1'b1;
    tick(1);
    faultReset <= 1'b0;
    tick(4);
    @(negedge clock);
    check({14'h0000, faultActive, servoIsOn}, 16'h0000);
    @(posedge clock);
    servoOnCmd <= 1'b1;
    step_up(1);
  endtask
  // clock source
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // warning monitor, matches each pulse against the oldest note
  always @(negedge clock) begin
    if (warningPulse === 1'b1) begin
      check({8'h00, warningCode}, {8'h00, expQ.size() > 0 ? expQ.pop_front() : 8'h00});
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    n_fail = 0;
    n_tests = 0;
    rstn = 1'b0;
    {servoOnCmd, faultIn, faultReset, netBrakeSet, netBrakeMask} = 5'h00;
    mainPowerOk = 1'b1;
    kick = 1'b1;
    kickSpeed = 16'h0000;
    stoppedBrakeTime = 16'h0001;
    movingBrakeDelayPeriod = 16'h000a;
    movingBrakeSpeed = 16'h0064;
    {disableOption, faultOption} = 6'h00;
    void'($urandom(32'ha3a3));
    tick(10);
    rstn <= 1'b1;
    disableOption <= 3'($urandom);
    faultOption <= 3'($urandom);
    tick(3);
    for (int i = 0; i < 4; i++) begin
      {netBrakeMask, netBrakeSet} <= 2'(i);
      @(negedge clock);
      check(16'(holdingBrakeReleaseOut), 16'(i == 2));
      @(posedge clock);
    end
    {netBrakeMask, netBrakeSet} <= 2'h0;
    kickSpeed <= 16'(32'h0000001f + $urandom % 32'h00000366);
    tick(2);
    servoOnCmd <= 1'b1;
    expQ.push_back(8'hb1);
    tick(4);
    @(negedge clock);
    check(16'(motorPower), 16'h0000);
    @(posedge clock);
    kick <= 1'b0;
    await(4, 2000);
    check(16'(motorSpeed <= 16'h001e), 16'h0001);
    step_up(0);
    @(posedge clock);
    {netBrakeMask, netBrakeSet} <= 2'h3;
    expQ.push_back(8'hb1);
    @(negedge clock);
    check(16'(holdingBrakeReleaseOut), 16'h0001);
    @(posedge clock);
    {netBrakeMask, netBrakeSet} <= 2'h0;
    kick <= 1'b1;
    kickSpeed <= 16'h01f4;
    mainPowerOk <= 1'b0;
    tick(3);
    @(negedge clock);
    check({12'h000, faultActive, motorPower, faultCode}, 16'h000a);
    check(16'(dynamicShortBrake), 16'(faultOption != 3'h0));
    @(posedge clock);
    kick <= 1'b0;
    await(2, 1000);
    check(16'(n >= 395 && n <= 410), 16'h0001);
    await(3, 1000);
    tick(20);
    @(negedge clock);
    check(16'(motorPower), 16'h0000);
    @(posedge clock);
    clear_fault();
    // external fault in motion: the brake delay ends the release before the speed does
    @(posedge clock);
    kick <= 1'b1;
    movingBrakeSpeed <= 16'h0000;
    movingBrakeDelayPeriod <= 16'h0003;
    @(posedge clock);
    kick <= 1'b0;
    faultIn <= 1'b1;
    @(posedge clock);
    faultIn <= 1'b0;
    await(2, 4 * TKC);
    check(16'(n >= 3 * TKC - 10 && n <= 3 * TKC + 10), 16'h0001);
    check(16'(faultCode), 16'h0001);
    await(3, 400);
    tick(4);
    @(negedge clock);
    check({14'h0000, faultActive, motorPower}, 16'h0002);
    @(posedge clock);
    clear_fault();
    // servo off in motion, servo on again while it slows
    @(posedge clock);
    kick <= 1'b1;
    @(posedge clock);
    kick <= 1'b0;
    servoOnCmd <= 1'b0;
    tick(2);
    @(negedge clock);
    check(16'(dynamicShortBrake), 16'(disableOption != 3'h0));
    check(16'(motorPower), 16'h0000);
    @(posedge clock);
    servoOnCmd <= 1'b1;
    await(2, 4 * TKC);
    check(16'(n >= 3 * TKC - 10 && n <= 3 * TKC + 10), 16'h0001);
    await(3, 400);
    check(16'(motorPower), 16'h0000);
    step_up(2);
    // servo off at rest
    @(posedge clock);
    servoOnCmd <= 1'b0;
    await(2, 3 * TKC);
    check(16'(n >= TKC && n <= 2 * TKC + 5), 16'h0001);
    tick(2);
    @(negedge clock);
    check(16'(motorPower), 16'h0000);
    check(16'(dynamicShortBrake), 16'(disableOption != 3'h0));
    check(16'(expQ.size()), 16'h0000);
    complete_run();
  end
endmodule
`default_nettype wire

//--- sebs_timer.sv
`timescale 1ns/1ps
`default_nettype none
// down counter: load then count to zero, done is a level at zero
module sebs_timer #(
  parameter int unsigned WIDTH = 24
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] value,
  output logic                  done
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;

  // elaboration check on the counter width
  if (WIDTH < 2) begin : g_badWidth
    $error("sebs_timer width too small");
  end

  // next count
  always_comb begin
    next_count = count;
    if (load) begin
      next_count = value;
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end
  end

  // count register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // done depends on the count only, so a load decided from done makes no loop
  assign done = count == '0;
endmodule
`default_nettype wire
